// *** design/rsl_params.svh ***
// register map, field positions and reset values of the receive status latch bank
`ifndef RSL_PARAMS_SVH
`define RSL_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define RSL_IDX_FRAMER_CTRL 10'h120
`define RSL_IDX_NONZERO_STATUS 10'h126
`define RSL_IDX_LATCH_ALARMS 10'h128
`define RSL_IDX_LATCH_ERRORS 10'h12a
`define RSL_IDX_ENABLE_ALARMS 10'h12c
`define RSL_IDX_ENABLE_ERRORS 10'h12e
`define RSL_IDX_FORMAT_CTRL 10'h13c

`define RSL_ADDR_FRAMER_CTRL ({`RSL_IDX_FRAMER_CTRL, 2'b00})
`define RSL_ADDR_NONZERO_STATUS ({`RSL_IDX_NONZERO_STATUS, 2'b00})
`define RSL_ADDR_LATCH_ALARMS ({`RSL_IDX_LATCH_ALARMS, 2'b00})
`define RSL_ADDR_LATCH_ERRORS ({`RSL_IDX_LATCH_ERRORS, 2'b00})
`define RSL_ADDR_ENABLE_ALARMS ({`RSL_IDX_ENABLE_ALARMS, 2'b00})
`define RSL_ADDR_ENABLE_ERRORS ({`RSL_IDX_ENABLE_ERRORS, 2'b00})
`define RSL_ADDR_FORMAT_CTRL ({`RSL_IDX_FORMAT_CTRL, 2'b00})

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RSL_FES_LSB 8
`define RSL_FES_MSB 9
`define RSL_FMT_UNCHAN_BIT 0
`define RSL_FMT_PORT_IE_BIT 1

// alarm latch bits
`define RSL_AL_MISMATCH 11
`define RSL_AL_APP_ID 10
`define RSL_AL_QUIET 9
`define RSL_AL_UNFRAMED 8
`define RSL_AL_MFRAME 7
`define RSL_AL_SEVERE 6
`define RSL_AL_ALIGN 5
`define RSL_AL_FLOSS 4
`define RSL_AL_REMOTE 3
`define RSL_AL_ALARM_IND 2
`define RSL_AL_SYNC 1
`define RSL_AL_SIGNAL 0

// error latch bits
`define RSL_ER_CBIT_EV 11
`define RSL_ER_FARB_EV 10
`define RSL_ER_PBIT_EV 9
`define RSL_ER_FRAME_EV 8
`define RSL_ER_CBIT_NZ 3
`define RSL_ER_FARB_NZ 2
`define RSL_ER_PBIT_NZ 1
`define RSL_ER_FRAME_NZ 0

// ----------------------------------------------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------------------------------------------
`define RSL_MASK_ALARMS 16'h0fff
`define RSL_MASK_ERRORS 16'h0f0f
`define RSL_MASK_NONZERO 16'h000f
`define RSL_RESET_REG16 16'h0000
`define RSL_RESET_FES 2'h0
`define RSL_RESET_FMT 2'h0

`endif

// *** design/rsl_pkg.sv ***
// types shared by the receive status latch bank
package rsl_pkg;

	// framing error count selection
	typedef enum logic [1:0] {
		RSL_FES_SYNC_LOSS = 2'b00,
		RSL_FES_M_AND_F = 2'b01,
		RSL_FES_F_ONLY = 2'b10,
		RSL_FES_M_ONLY = 2'b11
	} rsl_frame_err_sel_t;

endpackage

// *** design/rsl_latch_bank.sv ***
// bank of sticky write-one-to-clear event latches with change detection
`timescale 1ns/10ps
`default_nettype none

module rsl_latch_bank #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] ANY_MASK = '0,
	parameter logic [WIDTH-1:0] RISE_MASK = '0,
	parameter logic [WIDTH-1:0] PULSE_MASK = '0
) (
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// event sources
	input wire logic [WIDTH-1:0] i_level,
	input wire logic [WIDTH-1:0] i_pulse,
	input wire logic [WIDTH-1:0] i_hold_zero,
	// software clear, one cycle
	input wire logic [WIDTH-1:0] i_clear,
	// latched bits
	output logic [WIDTH-1:0] o_latched
);

	// ------------------------------------------------------------------------
	// priming
	// ------------------------------------------------------------------------
	// no change is seen until one real sample has been taken after reset
	logic primed_reg;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			primed_reg <= 1'b0;
		end else if (i_clk_en) begin
			primed_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// per-bit latch
	// ------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic prev_reg; // last sampled level
			logic set_evt; // event seen this cycle

			assign set_evt = (ANY_MASK[gi] & primed_reg & (i_level[gi] ^ prev_reg)) |
				(RISE_MASK[gi] & primed_reg & i_level[gi] & ~prev_reg) |
				(PULSE_MASK[gi] & i_pulse[gi]);

			// previous level for edge detection
			always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					prev_reg <= 1'b0;
				end else if (i_clk_en) begin
					prev_reg <= i_level[gi];
				end
			end

			// forced zero first, then set beats clear
			always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					o_latched[gi] <= 1'b0;
				end else if (i_clk_en) begin
					if (i_hold_zero[gi]) begin
						o_latched[gi] <= 1'b0;
					end else if (set_evt) begin
						o_latched[gi] <= 1'b1;
					end else if (i_clear[gi]) begin
						o_latched[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// *** design/rsl_status_latches.sv ***
// receive framer status, latched alarms and latched errors behind an apb slave
//
// Behaviour
// - c-bit count flag, zero in unchannelized format
// - far block count flag, zero in unchannelized format
// - p-bit count flag follows counter non-zero
// - frame error count flag follows counter
// - format mismatch latch on rising edge only
// - app id latch on any change
// - quiet and unframed-ones latches on any change
// - multiframe-lost and severe-error latches on change
// - frame-loss and remote-defect latches on change
// - alarm, sync-lost, signal-loss latches on change
// - alignment change latch on new alignment
// - c-bit event latch, zero in unchannelized format
// - far block event latch, zero in unchannelized
// - p-bit event latch per error
// - frame error event latch per selected event
// - c-bit nonzero rise latch, zero in unchannelized
// - selection picks sync loss, m+f, f, m
// - far block nonzero rise latch, zero unchannelized
// - p-bit and frame nonzero rise latches
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rsl_params.svh"

module rsl_status_latches #(
	parameter int ADDR_W = 12
) (
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// counter non-zero indications from the counters
	input wire logic i_cbit_parity_count_nonzero,
	input wire logic i_far_block_count_nonzero,
	input wire logic i_pbit_parity_count_nonzero,
	input wire logic i_frame_err_count_nonzero,
	// live framer condition levels
	input wire logic i_format_mismatch_state,
	input wire logic i_app_id_channel_state,
	input wire logic i_quiet_pattern_state,
	input wire logic i_unframed_ones_state,
	input wire logic i_multiframe_lost_state,
	input wire logic i_severe_frame_err_state,
	input wire logic i_frame_loss_state,
	input wire logic i_remote_defect_state,
	input wire logic i_alarm_indication_state,
	input wire logic i_frame_sync_lost_state,
	input wire logic i_signal_loss_state,
	// one-cycle event pulses from the detectors
	input wire logic i_alignment_change,
	input wire logic i_cbit_parity_err,
	input wire logic i_far_block_err,
	input wire logic i_pbit_parity_err,
	input wire logic i_fbit_err,
	input wire logic i_mbit_err,
	input wire logic i_frame_sync_lost_onset,
	// port enable from the global interrupt block
	input wire logic i_port_int_en,
	// outputs to counters and interrupt aggregation
	output logic [1:0] o_frame_err_count_select,
	output logic o_frame_err_event,
	output logic o_unchannelized_mux_format,
	output logic o_int
);

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	rsl_pkg::rsl_frame_err_sel_t fes_reg; // framing error count selection
	logic unchan_reg; // unchannelized mux format selected
	logic port_ie_reg; // local copy of a per-port enable qualifier
	logic [15:0] en_alarms_reg; // enables for latched alarms
	logic [15:0] en_errors_reg; // enables for latched errors
	logic [15:0] lat_alarms; // latched alarm bits
	logic [15:0] lat_errors; // latched error bits
	logic [15:0] nonzero_status; // live counter non-zero status
	logic frame_err_sel; // selected framing error event
	logic frame_err_event_reg; // registered selected event
	logic [31:0] prdata_reg; // read data, loaded in setup
	logic pslverr_reg; // unmapped address flag
	logic int_reg; // registered interrupt
	logic wr_acc; // write taking effect this edge
	logic setup; // apb setup cycle
	logic hit; // address is mapped
	logic [15:0] clr_alarms; // write-one-to-clear, alarms
	logic [15:0] clr_errors; // write-one-to-clear, errors
	logic [15:0] alarm_level; // alarm latch level sources
	logic [15:0] alarm_pulse; // alarm latch pulse sources
	logic [15:0] err_level; // error latch level sources
	logic [15:0] err_pulse; // error latch pulse sources
	logic [15:0] err_hold; // error bits held at zero
	logic [15:0] rd_mux; // read data selection

	// ------------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------------
	// zero wait states whenever the block is clocked; frozen otherwise
	assign o_pready = i_clk_en;
	assign setup = i_psel & ~i_penable;
	assign wr_acc = i_psel & i_penable & i_pwrite & i_clk_en;

	// address decode and read selection
	always_comb begin
		hit = 1'b1;
		rd_mux = `RSL_RESET_REG16;
		case (i_paddr)
			`RSL_ADDR_FRAMER_CTRL: begin
				rd_mux[`RSL_FES_MSB:`RSL_FES_LSB] = fes_reg;
			end
			`RSL_ADDR_NONZERO_STATUS: begin
				rd_mux = nonzero_status;
			end
			`RSL_ADDR_LATCH_ALARMS: begin
				rd_mux = lat_alarms;
			end
			`RSL_ADDR_LATCH_ERRORS: begin
				rd_mux = lat_errors;
			end
			`RSL_ADDR_ENABLE_ALARMS: begin
				rd_mux = en_alarms_reg;
			end
			`RSL_ADDR_ENABLE_ERRORS: begin
				rd_mux = en_errors_reg;
			end
			`RSL_ADDR_FORMAT_CTRL: begin
				rd_mux[`RSL_FMT_UNCHAN_BIT] = unchan_reg;
				rd_mux[`RSL_FMT_PORT_IE_BIT] = port_ie_reg;
			end
			default: begin
				hit = 1'b0; // unmapped: error answer, reads zero
			end
		endcase
	end

	// read data and error captured in setup, held through access
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (i_clk_en && setup) begin
			prdata_reg <= {16'h0000, rd_mux};
			pslverr_reg <= ~hit;
		end
	end

	assign o_prdata = prdata_reg;
	assign o_pslverr = pslverr_reg & i_psel & i_penable;

	// ------------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------------
	// framing error selection field
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fes_reg <= rsl_pkg::rsl_frame_err_sel_t'(`RSL_RESET_FES);
		end else if (wr_acc && i_paddr == `RSL_ADDR_FRAMER_CTRL) begin
			fes_reg <= rsl_pkg::rsl_frame_err_sel_t'(i_pwdata[`RSL_FES_MSB:`RSL_FES_LSB]);
		end
	end

	// format select and port enable qualifier
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{port_ie_reg, unchan_reg} <= `RSL_RESET_FMT;
		end else if (wr_acc && i_paddr == `RSL_ADDR_FORMAT_CTRL) begin
			unchan_reg <= i_pwdata[`RSL_FMT_UNCHAN_BIT];
			port_ie_reg <= i_pwdata[`RSL_FMT_PORT_IE_BIT];
		end
	end

	// per-bit interrupt enables, reserved bits stay zero
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_alarms_reg <= `RSL_RESET_REG16;
			en_errors_reg <= `RSL_RESET_REG16;
		end else if (wr_acc) begin
			if (i_paddr == `RSL_ADDR_ENABLE_ALARMS) begin
				en_alarms_reg <= i_pwdata[15:0] & `RSL_MASK_ALARMS;
			end
			if (i_paddr == `RSL_ADDR_ENABLE_ERRORS) begin
				en_errors_reg <= i_pwdata[15:0] & `RSL_MASK_ERRORS;
			end
		end
	end

	assign o_frame_err_count_select = fes_reg;
	assign o_unchannelized_mux_format = unchan_reg;

	// ------------------------------------------------------------------------
	// framing error event selection
	// ------------------------------------------------------------------------
	always_comb begin
		case (fes_reg)
			rsl_pkg::RSL_FES_SYNC_LOSS: frame_err_sel = i_frame_sync_lost_onset;
			rsl_pkg::RSL_FES_M_AND_F: frame_err_sel = i_mbit_err | i_fbit_err;
			rsl_pkg::RSL_FES_F_ONLY: frame_err_sel = i_fbit_err;
			rsl_pkg::RSL_FES_M_ONLY: frame_err_sel = i_mbit_err;
			default: frame_err_sel = 1'b0;
		endcase
	end

	// registered event feeds both the counter and the latch
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame_err_event_reg <= 1'b0;
		end else if (i_clk_en) begin
			frame_err_event_reg <= frame_err_sel;
		end
	end

	assign o_frame_err_event = frame_err_event_reg;

	// ------------------------------------------------------------------------
	// live counter non-zero status
	// ------------------------------------------------------------------------
	always_comb begin
		nonzero_status = `RSL_RESET_REG16;
		nonzero_status[`RSL_ER_CBIT_NZ] = i_cbit_parity_count_nonzero & ~unchan_reg;
		nonzero_status[`RSL_ER_FARB_NZ] = i_far_block_count_nonzero & ~unchan_reg;
		nonzero_status[`RSL_ER_PBIT_NZ] = i_pbit_parity_count_nonzero;
		nonzero_status[`RSL_ER_FRAME_NZ] = i_frame_err_count_nonzero;
	end

	// ------------------------------------------------------------------------
	// write-one-to-clear strobes
	// ------------------------------------------------------------------------
	assign clr_alarms = (wr_acc && i_paddr == `RSL_ADDR_LATCH_ALARMS) ? i_pwdata[15:0] : 16'h0000;
	assign clr_errors = (wr_acc && i_paddr == `RSL_ADDR_LATCH_ERRORS) ? i_pwdata[15:0] : 16'h0000;

	// ------------------------------------------------------------------------
	// alarm latch sources
	// ------------------------------------------------------------------------
	always_comb begin
		alarm_level = `RSL_RESET_REG16;
		alarm_pulse = `RSL_RESET_REG16;
		alarm_level[`RSL_AL_MISMATCH] = i_format_mismatch_state;
		alarm_level[`RSL_AL_APP_ID] = i_app_id_channel_state;
		alarm_level[`RSL_AL_QUIET] = i_quiet_pattern_state;
		alarm_level[`RSL_AL_UNFRAMED] = i_unframed_ones_state;
		alarm_level[`RSL_AL_MFRAME] = i_multiframe_lost_state;
		alarm_level[`RSL_AL_SEVERE] = i_severe_frame_err_state;
		alarm_pulse[`RSL_AL_ALIGN] = i_alignment_change;
		alarm_level[`RSL_AL_FLOSS] = i_frame_loss_state;
		alarm_level[`RSL_AL_REMOTE] = i_remote_defect_state;
		alarm_level[`RSL_AL_ALARM_IND] = i_alarm_indication_state;
		alarm_level[`RSL_AL_SYNC] = i_frame_sync_lost_state;
		alarm_level[`RSL_AL_SIGNAL] = i_signal_loss_state;
	end

	// mismatch latches on rising edge, alignment on pulse, the rest any change
	rsl_latch_bank #(
		.WIDTH(16),
		.ANY_MASK(16'h07df),
		.RISE_MASK(16'h0800),
		.PULSE_MASK(16'h0020)
	) u_alarm_bank (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_level(alarm_level),
		.i_pulse(alarm_pulse),
		.i_hold_zero(16'h0000),
		.i_clear(clr_alarms),
		.o_latched(lat_alarms)
	);

	// ------------------------------------------------------------------------
	// error latch sources
	// ------------------------------------------------------------------------
	always_comb begin
		err_level = `RSL_RESET_REG16;
		err_pulse = `RSL_RESET_REG16;
		err_hold = `RSL_RESET_REG16;
		err_pulse[`RSL_ER_CBIT_EV] = i_cbit_parity_err;
		err_pulse[`RSL_ER_FARB_EV] = i_far_block_err;
		err_pulse[`RSL_ER_PBIT_EV] = i_pbit_parity_err;
		err_pulse[`RSL_ER_FRAME_EV] = frame_err_event_reg;
		err_level[3:0] = nonzero_status[3:0];
		// c-bit and far block bits held clear in unchannelized format
		err_hold[`RSL_ER_CBIT_EV] = unchan_reg;
		err_hold[`RSL_ER_FARB_EV] = unchan_reg;
		err_hold[`RSL_ER_CBIT_NZ] = unchan_reg;
		err_hold[`RSL_ER_FARB_NZ] = unchan_reg;
	end

	// event bits on pulses, non-zero bits on rising edges
	rsl_latch_bank #(
		.WIDTH(16),
		.ANY_MASK(16'h0000),
		.RISE_MASK(16'h000f),
		.PULSE_MASK(16'h0f00)
	) u_error_bank (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_level(err_level),
		.i_pulse(err_pulse),
		.i_hold_zero(err_hold),
		.i_clear(clr_errors),
		.o_latched(lat_errors)
	);

	// ------------------------------------------------------------------------
	// interrupt
	// ------------------------------------------------------------------------
	// needs a set latch, its own enable and both port enables
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			int_reg <= 1'b0;
		end else if (i_clk_en) begin
			int_reg <= (|(lat_alarms & en_alarms_reg) | |(lat_errors & en_errors_reg)) &
				i_port_int_en & port_ie_reg;
		end
	end

	assign o_int = int_reg;

endmodule

`default_nettype wire

// *** dv/rsl_status_latches_chk.sv ***
// assertion checker for the receive status latch bank
`timescale 1ns/10ps
`default_nettype none
`include "rsl_params.svh"

module rsl_status_latches_chk #(
	parameter int ADDR_W = 12
) (
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	// framer inputs
	input wire logic i_cbit_parity_count_nonzero,
	input wire logic i_far_block_count_nonzero,
	input wire logic i_pbit_parity_count_nonzero,
	input wire logic i_frame_err_count_nonzero,
	input wire logic i_format_mismatch_state,
	input wire logic i_signal_loss_state,
	input wire logic i_pbit_parity_err,
	input wire logic i_fbit_err,
	input wire logic i_mbit_err,
	input wire logic i_frame_sync_lost_onset,
	input wire logic i_port_int_en,
	// block outputs
	input wire logic [1:0] o_frame_err_count_select,
	input wire logic o_frame_err_event,
	input wire logic o_unchannelized_mux_format,
	input wire logic o_int
);
	// ------------------------------------------------------------------
	// helper terms
	// ------------------------------------------------------------------
	logic rd_acc; // read access phase being taken
	logic [3:0] nz_in; // counter flags in status bit order
	logic sel_hit; // source picked by the selection field
	assign rd_acc = i_psel && i_penable && i_clk_en && !i_pwrite;
	assign nz_in = {i_cbit_parity_count_nonzero, i_far_block_count_nonzero,
		i_pbit_parity_count_nonzero, i_frame_err_count_nonzero};
	// decode of the framing error source
	always_comb begin
		case (o_frame_err_count_select)
			2'b00: sel_hit = i_frame_sync_lost_onset;
			2'b01: sel_hit = i_mbit_err || i_fbit_err;
			2'b10: sel_hit = i_fbit_err;
			default: sel_hit = i_mbit_err;
		endcase
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// ------------------------------------------------------------------
	// read sequences and assertions
	// ------------------------------------------------------------------
	sequence stat_rd;
		rd_acc && i_paddr == `RSL_ADDR_NONZERO_STATUS;
	endsequence
	sequence al_rd;
		rd_acc && i_paddr == `RSL_ADDR_LATCH_ALARMS;
	endsequence
	sequence err_rd;
		rd_acc && i_paddr == `RSL_ADDR_LATCH_ERRORS;
	endsequence
	nz_mask_a: assert property (stat_rd ##0 $past(o_unchannelized_mux_format) |-> o_prdata[3:2] == 2'b00)
		else $error("status flags not forced low");
	nz_follow_a: assert property (stat_rd ##0 ($past(nz_in) == $past(nz_in, 2) && !$past(o_unchannelized_mux_format)
		&& !$past(o_unchannelized_mux_format, 2)) |-> o_prdata[3:0] == $past(nz_in))
		else $error("status flags differ from counters");
	err_mask_a: assert property (err_rd ##0 ($past(o_unchannelized_mux_format) && $past(o_unchannelized_mux_format, 2))
		|-> o_prdata[11:10] == 2'b00 && o_prdata[3:2] == 2'b00)
		else $error("format-forced error latch set");
	pbit_ev_a: assert property (err_rd ##0 $past(i_pbit_parity_err, 2) |-> o_prdata[9])
		else $error("parity event not latched");
	mm_rise_a: assert property (al_rd ##0 ($past(i_format_mismatch_state, 2) && !$past(i_format_mismatch_state, 3))
		|-> o_prdata[11])
		else $error("mismatch rise not latched");
	sig_change_a: assert property (al_rd ##0 ($past(i_signal_loss_state, 2) != $past(i_signal_loss_state, 3))
		|-> o_prdata[0])
		else $error("signal loss change not latched");
	ev_cause_a: assert property (o_frame_err_event |-> $past(sel_hit))
		else $error("frame event without selected source");
	ev_follow_a: assert property ($past(sel_hit) && $past(i_clk_en) && $past(i_reset_n) |-> o_frame_err_event)
		else $error("selected source gave no frame event");
	int_gate_a: assert property (o_int && $past(i_clk_en) |-> $past(i_port_int_en))
		else $error("interrupt without port enable");
	sel_out_a: assert property (i_psel && i_penable && i_pwrite && i_clk_en && i_paddr == `RSL_ADDR_FRAMER_CTRL
		|=> o_frame_err_count_select == $past(i_pwdata[`RSL_FES_MSB:`RSL_FES_LSB]))
		else $error("selection output differs from written field");
endmodule

bind rsl_status_latches rsl_status_latches_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// *** dv/tb_rsl_status_latches.sv ***
// self-checking testbench for the receive status latch bank
`timescale 1ns/10ps
`default_nettype none
`include "rsl_params.svh"

module tb_rsl_status_latches;
	// ------------------------------------------------------------------
	// stimulus and observation
	// ------------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] nz = 4'h0; // counter flags: cbit, far block, pbit, frame
	logic [11:0] lvl = 12'h000; // condition levels in alarm bit order
	logic [6:0] pz = 7'h00; // pulses: onset, m, f, pbit, far block, cbit, alignment
	logic pie = 1'b0; // port interrupt enable
	logic ce = 1'b1; // block clock enable
	wire logic [31:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic irq;
	logic [32:0] expq[$]; // expected {pslverr, prdata} per read
	logic [32:0] e;
	logic [11:0] ea;
	logic [11:0] nv;
	logic [15:0] clr;
	logic hit;
	logic [11:0] addrs [7] = '{`RSL_ADDR_FRAMER_CTRL, `RSL_ADDR_NONZERO_STATUS, `RSL_ADDR_LATCH_ALARMS,
		`RSL_ADDR_LATCH_ERRORS, `RSL_ADDR_ENABLE_ALARMS, `RSL_ADDR_ENABLE_ERRORS, `RSL_ADDR_FORMAT_CTRL};
	int err_count = 0;
	int cmp_count = 0;

	rsl_status_latches #(.ADDR_W(12)) dut (
		.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_cbit_parity_count_nonzero(nz[3]), .i_far_block_count_nonzero(nz[2]),
		.i_pbit_parity_count_nonzero(nz[1]), .i_frame_err_count_nonzero(nz[0]),
		.i_format_mismatch_state(lvl[11]), .i_app_id_channel_state(lvl[10]), .i_quiet_pattern_state(lvl[9]),
		.i_unframed_ones_state(lvl[8]), .i_multiframe_lost_state(lvl[7]), .i_severe_frame_err_state(lvl[6]),
		.i_frame_loss_state(lvl[4]), .i_remote_defect_state(lvl[3]), .i_alarm_indication_state(lvl[2]),
		.i_frame_sync_lost_state(lvl[1]), .i_signal_loss_state(lvl[0]),
		.i_alignment_change(pz[0]), .i_cbit_parity_err(pz[1]), .i_far_block_err(pz[2]), .i_pbit_parity_err(pz[3]),
		.i_fbit_err(pz[4]), .i_mbit_err(pz[5]), .i_frame_sync_lost_onset(pz[6]), .i_port_int_en(pie),
		.o_frame_err_count_select(), .o_frame_err_event(), .o_unchannelized_mux_format(), .o_int(irq)
	);

	always #5 clk = ~clk;

	// ------------------------------------------------------------------
	// bus tasks: setup, access held until pready, one idle cycle
	// ------------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x,
		input logic [6:0] p);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) expq.push_back(x);
		@(posedge clk);
		penable <= 1'b1;
		pz <= p; // pulse lands on the taking edge
		@(posedge clk);
		pz <= 7'h00;
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] v, input logic er = 1'b0);
		apb(1'b0, a, 32'h0, {er, 16'h0, v}, 7'h00);
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [6:0] p = 7'h00);
		apb(1'b1, a, {16'h0, v}, 33'h0, p);
	endtask
	// interrupt line check at the settled falling edge
	task automatic chk(input logic v);
		@(negedge clk);
		cmp_count++;
		if (irq !== v) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, irq, v);
			err_count++;
		end
		@(posedge clk);
	endtask
	task automatic report_and_stop;
		$display("compares=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// monitor: compare each taken read with the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = expq.pop_front();
			cmp_count++;
			if ({pslverr, prdata} !== e) begin
				$display("mismatch t=%0t got=%h exp=%h", $time, {pslverr, prdata}, e);
				err_count++;
			end
		end
	end

	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(94));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// reset values, unmapped and read-only places
		foreach (addrs[i]) rd(addrs[i], 16'h0000);
		rd(12'h7fc, 16'h0000, 1'b1);
		wr(`RSL_ADDR_NONZERO_STATUS, 16'hffff);
		rd(`RSL_ADDR_NONZERO_STATUS, 16'h0000);
		// random condition changes, partial clears
		ea = 12'h000;
		for (int i = 0; i < 6; i++) begin
			nv = 12'($urandom()) & 12'hfdf;
			if (i == 0) nv = nv | 12'h801;
			ea = ea | ((nv ^ lvl) & 12'h7df) | {nv[11] & ~lvl[11], 11'h000};
			ea[5] = ea[5] | i[0];
			lvl <= nv;
			pz <= {6'h00, i[0]};
			@(posedge clk);
			pz <= 7'h00;
			rd(`RSL_ADDR_LATCH_ALARMS, {4'h0, ea});
			clr = 16'($urandom());
			wr(`RSL_ADDR_LATCH_ALARMS, clr);
			ea = ea & ~clr[11:0];
		end
		rd(`RSL_ADDR_LATCH_ALARMS, {4'h0, ea});
		// error events and counter flags in both formats
		for (int f = 0; f < 2; f++) begin
			wr(`RSL_ADDR_FORMAT_CTRL, {15'h0, f[0]});
			wr(`RSL_ADDR_LATCH_ERRORS, 16'hffff);
			nz <= 4'hf;
			pz <= 7'h0e;
			@(posedge clk);
			pz <= 7'h00;
			rd(`RSL_ADDR_LATCH_ERRORS, f ? 16'h0203 : 16'h0e0f);
			rd(`RSL_ADDR_NONZERO_STATUS, f ? 16'h0003 : 16'h000f);
			nz <= 4'h0;
		end
		// event on the same edge as its clear
		wr(`RSL_ADDR_FORMAT_CTRL, 16'h0000);
		wr(`RSL_ADDR_LATCH_ERRORS, 16'hffff);
		wr(`RSL_ADDR_LATCH_ERRORS, 16'h0200, 7'h08);
		rd(`RSL_ADDR_LATCH_ERRORS, 16'h0200);
		// a pulse while the clock enable is low must leave no trace
		wr(`RSL_ADDR_LATCH_ERRORS, 16'hffff);
		ce <= 1'b0;
		pz <= 7'h08;
		@(posedge clk);
		ce <= 1'b1;
		pz <= 7'h00;
		@(posedge clk);
		rd(`RSL_ADDR_LATCH_ERRORS, 16'h0000);
		// every selection against every framing source
		for (int s = 0; s < 4; s++) begin
			wr(`RSL_ADDR_FRAMER_CTRL, 16'(s << 8));
			rd(`RSL_ADDR_FRAMER_CTRL, 16'(s << 8));
			for (int k = 0; k < 3; k++) begin
				wr(`RSL_ADDR_LATCH_ERRORS, 16'hffff);
				pz <= 7'h10 << k;
				@(posedge clk);
				pz <= 7'h00;
				repeat (2) @(posedge clk);
				hit = (s == 0) ? (k == 2) : (s == 1) ? (k < 2) : (s == 2) ? (k == 0) : (k == 1);
				rd(`RSL_ADDR_LATCH_ERRORS, {7'h00, hit, 8'h00});
			end
		end
		// interrupt: raise, port mask, own mask, clear
		wr(`RSL_ADDR_LATCH_ALARMS, 16'hffff);
		wr(`RSL_ADDR_ENABLE_ALARMS, 16'h0001);
		wr(`RSL_ADDR_FORMAT_CTRL, 16'h0002);
		pie <= 1'b1;
		lvl[0] <= ~lvl[0];
		repeat (2) @(posedge clk);
		chk(1'b1);
		pie <= 1'b0;
		@(posedge clk);
		chk(1'b0);
		pie <= 1'b1;
		wr(`RSL_ADDR_ENABLE_ALARMS, 16'h0000);
		chk(1'b0);
		wr(`RSL_ADDR_ENABLE_ALARMS, 16'h0001);
		chk(1'b1);
		wr(`RSL_ADDR_LATCH_ALARMS, 16'h0001);
		chk(1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire
